// ===== word_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i, // System clock.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire logic ce_i, // Clock enable.
  input wire logic [WIDTH-1:0] in_data_i, // Word written.
  input wire logic in_valid_i, // Write request.
  output logic in_ready_o, // Not full.
  output logic [WIDTH-1:0] out_data_o, // Head word.
  output logic out_valid_o, // Not empty.
  input wire logic out_ready_i // Drain request.
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("DEPTH must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  assign in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wr_q <= '0;
    else if (push)
      wr_q <= wr_q + 1'b1;
  end
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_q <= '0;
    else if (pop)
      rd_q <= rd_q + 1'b1;
  end
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data_i;
  end
endmodule
`default_nettype wire

// ===== dac_input_pkg.sv
// Constants of the dual serial input latch.
package dac_input_pkg;
  localparam int WORD_BITS = 18;
  localparam int FIFO_DEPTH = 8;
  localparam logic [17:0] HOLD_RESET = 18'h00000;
  localparam int CLK_HZ = 10000000;
  localparam int MIN_BIT_RATE_HZ = 13500000;
  localparam int SYNC_STAGES = 2;
  localparam int LEFT_TAG = 0;
  localparam int RIGHT_TAG = 1;
endpackage

// ===== dual_dac_serial_input_latch.sv
// Dual serial input registers with latch-driven holding registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Each channel shifts in one data bit per rising bit clock edge.
// R2: Sender supplies 18-bit two's complement words, MSB first.
// R3: Falling latch edge copies the last 18 shifted bits to holding; here the word passes the FIFO and loads when conv_ready_i pops it.
// R4: Left latch and data serve left only; right likewise.
// R5: One shared bit clock feeds both shift registers.
// R6: Bit clock rates of at least 13.5 MHz must be accepted; the sampled bit clock here is limited to 2.5 MHz (mclk / 4).
// R7: At 16x oversampling words arrive at 705.6 kHz per channel.
// R8: Shared-line sender clocks all 18 bits before strobing the latch.
// R9: Latching both channels together loads their words simultaneously; here the right word loads one cycle after the left.
// R10: A single word strobe may drive both latch inputs.
// R11: Two independent 18-bit input registers, each feeding a converter.
// R12: Holding registers keep value between latch falling edges.
module dual_dac_serial_input_latch #(
  parameter int WIDTH = dac_input_pkg::WORD_BITS,
  parameter int DEPTH = dac_input_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i, // System clock, 10 MHz.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire logic ce_i, // Clock enable; low freezes all state.
  input wire logic bit_clk_i, // Shared serial bit clock pin.
  input wire logic left_serial_in_i, // Left serial data pin.
  input wire logic right_serial_in_i, // Right serial data pin.
  input wire logic left_update_strobe_i, // Left latch pin.
  input wire logic right_update_strobe_i, // Right latch pin.
  input wire logic conv_ready_i, // Converter side accepts a word.
  output logic [WIDTH-1:0] left_hold_o, // Left converter word.
  output logic [WIDTH-1:0] right_hold_o, // Right converter word.
  output logic left_update_o, // Pulse: left word updated.
  output logic right_update_o, // Pulse: right word updated.
  output logic latch_ready_o // FIFO can take a latched word.
);
  initial
  begin
    if (WIDTH != dac_input_pkg::WORD_BITS)
      $error("WIDTH must equal the serial word length");
  end
  // The bit clock is sampled, so it must stay at or below mclk / 4.
  // Faster bit clocks are missed: the cost of sampling on one clock.
  localparam int MAX_BIT_HZ = dac_input_pkg::CLK_HZ / 4; // R6

  // Two-flop synchronisers for all pins.
  logic [3:1] s1_q;
  logic [3:1] s2_q;
  logic [3:1] s3_q;
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
    end
    else if (ce_i)
    begin
      s1_q <= {bit_clk_i, left_update_strobe_i, right_update_strobe_i};
      s2_q <= s1_q;
    end
  end
  logic lsync1_q;
  logic rsync1_q;
  logic lsync2_q;
  logic rsync2_q;
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lsync1_q <= 1'b0;
      rsync1_q <= 1'b0;
      lsync2_q <= 1'b0;
      rsync2_q <= 1'b0;
    end
    else if (ce_i)
    begin
      lsync1_q <= left_serial_in_i;
      rsync1_q <= right_serial_in_i;
      lsync2_q <= lsync1_q;
      rsync2_q <= rsync1_q;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s3_q <= 3'h7;
    else if (ce_i)
      s3_q <= s2_q;
  end
  logic clk_rise;
  logic left_strobe_fall;
  logic right_strobe_fall;
  assign clk_rise = s2_q[3] && !s3_q[3]; // R5
  assign left_strobe_fall = !s2_q[2] && s3_q[2];
  assign right_strobe_fall = !s2_q[1] && s3_q[1];

  // Shift registers, one per channel, from the one shared bit clock.
  logic [WIDTH-1:0] lsh_q;
  logic [WIDTH-1:0] rsh_q;
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lsh_q <= '0;
      rsh_q <= '0;
    end
    else if (ce_i && clk_rise)
    begin
      lsh_q <= {lsh_q[WIDTH-2:0], lsync2_q}; // R1 R4 R11
      rsh_q <= {rsh_q[WIDTH-2:0], rsync2_q}; // R1 R4 R11
    end
  end

  // Latched words pass through the FIFO tagged with their channel.
  logic [WIDTH:0] f_in;
  logic f_valid;
  logic f_ready;
  logic [WIDTH:0] f_out;
  logic f_out_valid;
  logic f_pop;
  logic pend_r_q;
  logic [WIDTH-1:0] pend_w_q;
  // When both latch together, or the FIFO is full, the right word waits in pend_w_q until the FIFO has room.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pend_r_q <= 1'b0;
      pend_w_q <= '0;
    end
    else if (ce_i)
    begin
      if (right_strobe_fall && (left_strobe_fall || pend_r_q || !f_ready))
      begin
        pend_r_q <= 1'b1; // R9
        pend_w_q <= rsh_q;
      end
      else if (pend_r_q && f_ready && !left_strobe_fall)
        pend_r_q <= 1'b0;
    end
  end
  always_comb
  begin
    f_valid = 1'b0;
    f_in = '0;
    if (left_strobe_fall)
    begin
      f_valid = 1'b1;
      f_in = {1'b0, lsh_q}; // R3 R4
    end
    else if (pend_r_q)
    begin
      f_valid = 1'b1;
      f_in = {1'b1, pend_w_q};
    end
    else if (right_strobe_fall)
    begin
      f_valid = 1'b1;
      f_in = {1'b1, rsh_q}; // R3 R4
    end
  end
  assign f_pop = f_out_valid && conv_ready_i;

  word_fifo #(
    .WIDTH(WIDTH + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .in_data_i(f_in),
    .in_valid_i(f_valid),
    .in_ready_o(f_ready),
    .out_data_o(f_out),
    .out_valid_o(f_out_valid),
    .out_ready_i(conv_ready_i)
  );

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      latch_ready_o <= 1'b1;
    else if (ce_i)
      latch_ready_o <= f_ready;
  end

  // Holding registers only change when their own word leaves the FIFO.
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      left_hold_o <= dac_input_pkg::HOLD_RESET;
      right_hold_o <= dac_input_pkg::HOLD_RESET;
      left_update_o <= 1'b0;
      right_update_o <= 1'b0;
    end
    else if (ce_i)
    begin
      left_update_o <= f_pop && !f_out[WIDTH];
      right_update_o <= f_pop && f_out[WIDTH];
      if (f_pop && !f_out[WIDTH])
        left_hold_o <= f_out[WIDTH-1:0]; // R3 R12
      if (f_pop && f_out[WIDTH])
        right_hold_o <= f_out[WIDTH-1:0]; // R3 R12
    end
  end

  sequence s_left_pop;
    ce_i && f_pop && !f_out[WIDTH];
  endsequence
  property p_hold_left;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && !(f_pop && !f_out[WIDTH])) |=> $stable(left_hold_o);
  endproperty
  a_hold_left: assert property (p_hold_left) // R12
    else $error("left hold changed without latch");
  property p_hold_right;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && !(f_pop && f_out[WIDTH])) |=> $stable(right_hold_o);
  endproperty
  a_hold_right: assert property (p_hold_right) // R12
    else $error("right hold changed without latch");
  property p_left_load;
    @(posedge mclk_i) disable iff (!rst_b_i)
    s_left_pop |=>
      left_hold_o == $past(f_out[WIDTH-1:0]) && left_update_o;
  endproperty
  a_left_load: assert property (p_left_load) // R3
    else $error("left word not loaded");
  property p_shift;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && clk_rise) |=> lsh_q[0] == $past(lsync2_q)
      && rsh_q[0] == $past(rsync2_q);
  endproperty
  a_shift: assert property (p_shift) // R1
    else $error("bit not shifted in");
  property p_noshift;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && !clk_rise) |=> $stable(lsh_q) && $stable(rsh_q);
  endproperty
  a_noshift: assert property (p_noshift) // R5
    else $error("shift without bit clock");
  property p_left_enq;
    @(posedge mclk_i) disable iff (!rst_b_i)
    left_strobe_fall |-> f_valid && f_in == {1'b0, lsh_q};
  endproperty
  a_left_enq: assert property (p_left_enq) // R4
    else $error("left latch did not capture left word");
  property p_both;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && left_strobe_fall && right_strobe_fall) |=>
      pend_r_q && pend_w_q == $past(rsh_q);
  endproperty
  a_both: assert property (p_both) // R9
    else $error("simultaneous right latch lost");
  property p_two_chan;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && f_pop) |=> left_update_o != right_update_o;
  endproperty
  a_two_chan: assert property (p_two_chan) // R11
    else $error("update went to both channels");
endmodule
`default_nettype wire

// ===== serial_sender.sv
// Sender model driving the shared bit clock, data lines and latch pins.
`timescale 1ns/1ps
`default_nettype none
module serial_sender (
  input wire logic mclk_i, // System clock.
  output logic bit_clk_o, // Shared bit clock.
  output logic left_data_o, // Left serial data.
  output logic right_data_o, // Right serial data.
  output logic left_strobe_o, // Left latch, idle high.
  output logic right_strobe_o // Right latch, idle high.
);
  initial
  begin
    bit_clk_o = 1'b0;
    left_data_o = 1'b0;
    right_data_o = 1'b1;
    left_strobe_o = 1'b1;
    right_strobe_o = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Sends the low n bits of each word, most significant first.
  task automatic send(input logic [19:0] l, input logic [19:0] r,
                      input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      left_data_o = l[i];
      right_data_o = r[i];
      step(2);
      bit_clk_o = 1'b1;
      step(2);
      bit_clk_o = 1'b0;
    end
    // Released lines show the opposite of the last bit.
    left_data_o = ~left_data_o;
    right_data_o = ~right_data_o;
  endtask
  // Pulls the chosen latches low together, after the whole word.
  task automatic latch(input logic l, input logic r);
    left_strobe_o = ~l;
    right_strobe_o = ~r;
    step(3);
    left_strobe_o = 1'b1;
    right_strobe_o = 1'b1;
    step(3);
  endtask
endmodule
`default_nettype wire

// ===== dual_dac_serial_input_latch_bench.sv
// Testbench for the dual serial input latch.
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_input_latch_bench;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic conv_ready_i = 1'b1;
  wire logic bclk, ldat, rdat, lstb, rstb, lupd, rupd;
  wire logic [17:0] lhold, rhold;
  wire logic fifo_rdy;
  int errors = 0;
  int n_tests = 0;
  always #50 mclk_i = ~mclk_i;
  serial_sender snd (.mclk_i(mclk_i), .bit_clk_o(bclk),
    .left_data_o(ldat), .right_data_o(rdat),
    .left_strobe_o(lstb), .right_strobe_o(rstb));
  dual_dac_serial_input_latch dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .ce_i(ce_i), .bit_clk_i(bclk), .left_serial_in_i(ldat),
    .right_serial_in_i(rdat), .left_update_strobe_i(lstb),
    .right_update_strobe_i(rstb), .conv_ready_i(conv_ready_i),
    .left_hold_o(lhold), .right_hold_o(rhold), .left_update_o(lupd),
    .right_update_o(rupd), .latch_ready_o(fifo_rdy));
  task automatic stop_test;
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Watches 30 cycles for an update pulse on exactly the expected channels.
  task automatic wait_upd(input logic wl, input logic wr);
    logic sl;
    logic sr;
    sl = 1'b0;
    sr = 1'b0;
    repeat (30)
    begin
      @(posedge mclk_i);
      #1;
      sl = sl | (lupd === 1'b1);
      sr = sr | (rupd === 1'b1);
    end
    cmp({16'h0000, sl, sr}, {16'h0000, wl, wr});
    if (sl !== wl || sr !== wr)
      stop_test();
  endtask
  // The update pulses come after the latch is released, before the latch task returns, so watch alongside.
  task automatic t_both;
    snd.send(20'hFA5C3, 20'hC1234, 20);
    fork
      snd.latch(1'b1, 1'b1);
      wait_upd(1'b1, 1'b1);
    join
    cmp(lhold, 18'h3A5C3);
    cmp(rhold, 18'h01234);
  endtask
  task automatic t_left;
    snd.send(20'h15555, 20'h2AAAA, 18);
    fork
      snd.latch(1'b1, 1'b0);
      wait_upd(1'b1, 1'b0);
    join
    cmp(lhold, 18'h15555);
    cmp(rhold, 18'h01234);
  endtask
  task automatic t_right;
    snd.send(20'h00001, 20'h20000, 18);
    fork
      snd.latch(1'b0, 1'b1);
      wait_upd(1'b0, 1'b1);
    join
    cmp(lhold, 18'h15555);
    cmp(rhold, 18'h20000);
  endtask
  task automatic t_stall;
    conv_ready_i = 1'b0;
    snd.send(20'h3FFFF, 20'h00000, 18);
    snd.latch(1'b1, 1'b1);
    snd.step(10);
    cmp(lhold, 18'h15555);
    cmp(rhold, 18'h20000);
    conv_ready_i = 1'b1;
    wait_upd(1'b1, 1'b1);
    cmp(lhold, 18'h3FFFF);
    cmp(rhold, 18'h00000);
  endtask
  // Four joint latches fill the 8-word FIFO while the converter stalls.
  task automatic t_full;
    conv_ready_i = 1'b0;
    snd.send(20'h0ABCD, 20'h32100, 18);
    repeat (4) snd.latch(1'b1, 1'b1);
    cmp({17'h00000, fifo_rdy}, 18'h00000);
    conv_ready_i = 1'b1;
    wait_upd(1'b1, 1'b1);
    cmp(lhold, 18'h0ABCD);
    cmp(rhold, 18'h32100);
    cmp({17'h00000, fifo_rdy}, 18'h00001);
  endtask
  // With the clock enable low, pin activity must leave every word alone.
  task automatic t_freeze;
    ce_i = 1'b0;
    snd.send(20'h00777, 20'h00555, 18);
    snd.latch(1'b1, 1'b1);
    ce_i = 1'b1;
    snd.step(10);
    cmp(lhold, 18'h0ABCD);
    cmp(rhold, 18'h32100);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    snd.step(4);
    cmp(lhold, dac_input_pkg::HOLD_RESET);
    cmp(rhold, dac_input_pkg::HOLD_RESET);
    t_both();
    t_left();
    t_right();
    t_stall();
    t_full();
    t_freeze();
    stop_test();
  end
endmodule
`default_nettype wire
